// ### shared/pms_pkg.sv
// Shared constants and state encoding of the power mode sequencer
package pms_pkg;
    // Power states, binary codes
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h0,
        ST_IDLE = 3'h1,
        ST_SLEEP = 3'h2,
        ST_DRS = 3'h3,
        ST_SDS = 3'h4,
        ST_HIB_T = 3'h5,
        ST_HIB_E = 3'h6,
        ST_OFF = 3'h7
    } pms_state_t;
    // State after reset
    localparam pms_state_t RST_STATE = ST_ACTIVE;
    // Default number of gateable clocks
    localparam int N_CLK_DEF = 4;
    // Default always-on memory shape
    localparam int AON_WORDS_DEF = 16;
    localparam int AON_WIDTH_DEF = 8;
    // Default hibernate interval in oscillator ticks
    localparam int HIB_TICKS_DEF = 32768;
    // Width of the hibernate tick counter
    localparam int HIB_CNT_W = 32;
    // Shutdown threshold window of the detector, millivolts
    localparam int SHUTDOWN_THRESHOLD_MIN_MV = 1625;
    localparam int SHUTDOWN_THRESHOLD_MAX_MV = 1760;
endpackage : pms_pkg

// ### verilog/pms_wake_timer.sv
// Oscillator-tick timer that ends a timed hibernate
`timescale 1ns/1ps
module pms_wake_timer #(
    parameter int TICKS = pms_pkg::HIB_TICKS_DEF
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic lpo_tick_i,
    output logic expire_o
);
    // Ticks seen since the run started
    logic [pms_pkg::HIB_CNT_W-1:0] count;
    // Last tick index, at counter width
    localparam logic [pms_pkg::HIB_CNT_W-1:0] LAST = pms_pkg::HIB_CNT_W'(TICKS - 1);

    // Counter restarts whenever the run level drops
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !run_i) begin
            count <= '0;
        end else if (lpo_tick_i && count != LAST) begin
            count <= count + 1'b1;
        end
    end

    // One pulse on the tick that completes the interval
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= run_i && lpo_tick_i && (count == LAST) && !expire_o;
        end
    end
endmodule // pms_wake_timer

// ### verilog/pms_sequencer.sv
// Power mode sequencer: state machine, clock and power gating, wake logic
`timescale 1ns/1ps
module pms_sequencer #(
    parameter int N_CLK = pms_pkg::N_CLK_DEF,
    parameter int AON_WORDS = pms_pkg::AON_WORDS_DEF,
    parameter int AON_WIDTH = pms_pkg::AON_WIDTH_DEF,
    parameter int HIB_TICKS = pms_pkg::HIB_TICKS_DEF
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic req_idle_i,
    input wire logic req_sleep_i,
    input wire logic req_drs_i,
    input wire logic req_sds_i,
    input wire logic req_hib_timed_i,
    input wire logic req_hib_ext_i,
    input wire logic irq_i,
    input wire logic radio_wake_i,
    input wire logic ext_irq_i,
    input wire logic supply_low_i,
    input wire logic lpo_tick_i,
    input wire logic radio_task_keep_i,
    input wire logic [N_CLK-1:0] clk_gate_allow_i,
    input wire logic aon_wr_i,
    input wire logic [$clog2(AON_WORDS)-1:0] aon_addr_i,
    input wire logic [AON_WIDTH-1:0] aon_wdata_i,
    output logic [2:0] state_o,
    output logic cpu_run_o,
    output logic cpu_wait_o,
    output logic hclk_en_o,
    output logic hclk_slow_o,
    output logic [N_CLK-1:0] clk_en_o,
    output logic ldo_low_o,
    output logic periph_pwr_o,
    output logic core_pwr_o,
    output logic sram_retain_o,
    output logic io_pwr_o,
    output logic rtc_en_o,
    output logic lpo_en_o,
    output logic radio_task_en_o,
    output logic resume_o,
    output logic warm_boot_o,
    output logic aon_valid_o,
    output logic [AON_WIDTH-1:0] aon_rdata_o
);
    // Current and next power state
    pms_pkg::pms_state_t state;
    pms_pkg::pms_state_t next_state;
    // Timer expiry pulse
    logic hib_expire;
    // Wake qualifiers
    logic light_wake;
    logic core_on;
    // Always-on memory, kept through every low-power state
    logic [AON_WIDTH-1:0] aon_mem [AON_WORDS];

    // Any interrupt or wake source ends the light modes
    assign light_wake = irq_i || radio_wake_i || ext_irq_i;
    // Core domain alive: processor can issue requests
    assign core_on = (state == pms_pkg::ST_ACTIVE) || (state == pms_pkg::ST_IDLE) ||
                     (state == pms_pkg::ST_SLEEP) || (state == pms_pkg::ST_DRS);

    // Hibernate timer runs only in timed hibernate
    pms_wake_timer #(
        .TICKS(HIB_TICKS)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .run_i(state == pms_pkg::ST_HIB_T),
        .lpo_tick_i(lpo_tick_i),
        .expire_o(hib_expire)
    );

    // Next state: low supply first, then hibernate, then ordered requests
    always_comb begin
        next_state = state;
        if (supply_low_i) begin
            next_state = pms_pkg::ST_OFF;
        end else if (core_on && req_hib_ext_i) begin
            next_state = pms_pkg::ST_HIB_E;
        end else if (core_on && req_hib_timed_i) begin
            next_state = pms_pkg::ST_HIB_T;
        end else begin
            case (state)
                pms_pkg::ST_ACTIVE: begin
                    // Deepest request wins when several arrive together
                    if (req_sds_i) begin
                        next_state = pms_pkg::ST_SDS;
                    end else if (req_drs_i) begin
                        next_state = pms_pkg::ST_DRS;
                    end else if (req_sleep_i) begin
                        next_state = pms_pkg::ST_SLEEP;
                    end else if (req_idle_i) begin
                        next_state = pms_pkg::ST_IDLE;
                    end
                end
                pms_pkg::ST_IDLE, pms_pkg::ST_SLEEP, pms_pkg::ST_DRS: begin
                    // Light modes return to full speed on any wake
                    if (light_wake) begin
                        next_state = pms_pkg::ST_ACTIVE;
                    end
                end
                pms_pkg::ST_SDS: begin
                    // Radio activity or external line only
                    if (radio_wake_i || ext_irq_i) begin
                        next_state = pms_pkg::ST_ACTIVE;
                    end
                end
                pms_pkg::ST_HIB_T: begin
                    // Only the oscillator timer ends this state
                    if (hib_expire) begin
                        next_state = pms_pkg::ST_ACTIVE;
                    end
                end
                pms_pkg::ST_HIB_E: begin
                    // Timer is stopped here, so external line alone wakes
                    if (ext_irq_i) begin
                        next_state = pms_pkg::ST_ACTIVE;
                    end
                end
                pms_pkg::ST_OFF: begin
                    // Restart once the supply is back in range
                    next_state = pms_pkg::ST_ACTIVE;
                end
                default: begin
                    next_state = pms_pkg::ST_OFF;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= pms_pkg::RST_STATE;
        end else begin
            state <= next_state;
        end
    end

    // Processor and system clock controls, decoded from the next state
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_o <= 3'h0;
            cpu_run_o <= 1'b1;
            cpu_wait_o <= 1'b0;
            hclk_en_o <= 1'b1;
            hclk_slow_o <= 1'b0;
        end else begin
            state_o <= next_state;
            // Full speed only in active
            cpu_run_o <= (next_state == pms_pkg::ST_ACTIVE);
            // Processor parks in wait-for-interrupt in idle, sleep, deep retention
            cpu_wait_o <= (next_state == pms_pkg::ST_IDLE) ||
                          (next_state == pms_pkg::ST_SLEEP) ||
                          (next_state == pms_pkg::ST_DRS);
            // System clock runs in active and idle only
            hclk_en_o <= (next_state == pms_pkg::ST_ACTIVE) ||
                         (next_state == pms_pkg::ST_IDLE);
            // Idle keeps the clock at a reduced rate
            hclk_slow_o <= (next_state == pms_pkg::ST_IDLE);
        end
    end

    // Other clocks: on in active and idle, gated per allow bit in sleep and deep retention
    genvar gi;
    generate
        for (gi = 0; gi < N_CLK; gi++) begin : g_clk
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    clk_en_o[gi] <= 1'b1;
                end else begin
                    case (next_state)
                        pms_pkg::ST_ACTIVE, pms_pkg::ST_IDLE: begin
                            clk_en_o[gi] <= 1'b1;
                        end
                        pms_pkg::ST_SLEEP, pms_pkg::ST_DRS: begin
                            // Allow bit is sampled every cycle, so it may change mid-sleep
                            clk_en_o[gi] <= !clk_gate_allow_i[gi];
                        end
                        default: begin
                            // Core domain off, nothing left to clock
                            clk_en_o[gi] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Power domains and regulator level
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ldo_low_o <= 1'b0;
            periph_pwr_o <= 1'b1;
            core_pwr_o <= 1'b1;
            sram_retain_o <= 1'b1;
            io_pwr_o <= 1'b1;
            rtc_en_o <= 1'b1;
            lpo_en_o <= 1'b1;
        end else begin
            // Lower regulator while retention still holds state
            ldo_low_o <= (next_state == pms_pkg::ST_SLEEP) ||
                         (next_state == pms_pkg::ST_DRS);
            // Serial ports and most peripherals drop in deep retention
            periph_pwr_o <= (next_state == pms_pkg::ST_ACTIVE) ||
                            (next_state == pms_pkg::ST_IDLE) ||
                            (next_state == pms_pkg::ST_SLEEP);
            // Core and memory survive only the retention states
            core_pwr_o <= (next_state != pms_pkg::ST_SDS) &&
                          (next_state != pms_pkg::ST_HIB_T) &&
                          (next_state != pms_pkg::ST_HIB_E) &&
                          (next_state != pms_pkg::ST_OFF);
            sram_retain_o <= (next_state != pms_pkg::ST_SDS) &&
                             (next_state != pms_pkg::ST_HIB_T) &&
                             (next_state != pms_pkg::ST_HIB_E) &&
                             (next_state != pms_pkg::ST_OFF);
            // Io domain stays up except in the forced supply shutdown
            io_pwr_o <= (next_state != pms_pkg::ST_OFF);
            // Oscillator and rtc stop in interrupt hibernate and supply shutdown
            rtc_en_o <= (next_state != pms_pkg::ST_HIB_E) &&
                        (next_state != pms_pkg::ST_OFF);
            lpo_en_o <= (next_state != pms_pkg::ST_HIB_E) &&
                        (next_state != pms_pkg::ST_OFF);
        end
    end

    // Radio task kept alive through shutdown sleep when firmware asks
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            radio_task_en_o <= 1'b0;
        end else begin
            // Core states run the radio under firmware; shutdown keeps one task
            radio_task_en_o <= (next_state == pms_pkg::ST_SDS) && radio_task_keep_i;
        end
    end

    // Exit pulses: resume after deep retention, warm boot after power loss
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            resume_o <= 1'b0;
            warm_boot_o <= 1'b0;
        end else begin
            resume_o <= (state == pms_pkg::ST_DRS) &&
                        (next_state == pms_pkg::ST_ACTIVE);
            warm_boot_o <= !core_on && (next_state == pms_pkg::ST_ACTIVE);
        end
    end

    // Always-on memory: writes only while the core can issue them
    always_ff @(posedge clk_sys_i) begin
        // No reset on the array: its contents must outlive every state
        if (aon_wr_i && core_on && !srst_i) begin
            aon_mem[aon_addr_i] <= aon_wdata_i;
        end
    end

    // Read port, valid whenever the core domain is back up
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            aon_valid_o <= 1'b0;
            aon_rdata_o <= '0;
        end else begin
            // Decoded from the next state so it is already up in the first cycle back
            aon_valid_o <= (next_state == pms_pkg::ST_ACTIVE) ||
                           (next_state == pms_pkg::ST_IDLE) ||
                           (next_state == pms_pkg::ST_SLEEP) ||
                           (next_state == pms_pkg::ST_DRS);
            aon_rdata_o <= aon_mem[aon_addr_i];
        end
    end

    // Checks on the sequencing
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // Leaving deep retention back to active
    sequence s_leave_drs;
        (state == pms_pkg::ST_DRS) ##1 (state == pms_pkg::ST_ACTIVE);
    endsequence
    // Leaving shutdown sleep back to active
    sequence s_leave_sds;
        (state == pms_pkg::ST_SDS) ##1 (state == pms_pkg::ST_ACTIVE);
    endsequence

    AST_ACTIVE_FULL: assert property (
        (state == pms_pkg::ST_ACTIVE) |-> cpu_run_o && hclk_en_o && !hclk_slow_o &&
            periph_pwr_o && (clk_en_o == {N_CLK{1'b1}}))
        else $error("active state not at full speed");
    AST_IDLE_SLOW: assert property (
        (state == pms_pkg::ST_IDLE) |-> cpu_wait_o && hclk_en_o && hclk_slow_o &&
            sram_retain_o)
        else $error("idle clocking wrong");
    AST_SLEEP_STOP: assert property (
        (state == pms_pkg::ST_SLEEP) |-> cpu_wait_o && !hclk_en_o && ldo_low_o)
        else $error("sleep left system clock running");
    AST_SLEEP_GATE: assert property (
        (state == pms_pkg::ST_SLEEP) |-> (clk_en_o == ~$past(clk_gate_allow_i)))
        else $error("sleep clock gating does not follow allow bits");
    AST_DRS_PERIPH: assert property (
        (state == pms_pkg::ST_DRS) |-> !periph_pwr_o && sram_retain_o && core_pwr_o)
        else $error("deep retention power wrong");
    AST_DRS_RESUME: assert property (
        s_leave_drs |-> resume_o && !warm_boot_o)
        else $error("deep retention exit not a resume");
    AST_SDS_WARM: assert property (
        s_leave_sds |-> warm_boot_o && !resume_o && aon_valid_o)
        else $error("shutdown exit not a warm boot");
    AST_SDS_WAKE: assert property (
        (state == pms_pkg::ST_SDS) && !supply_low_i && (radio_wake_i || ext_irq_i)
            |=> (state == pms_pkg::ST_ACTIVE))
        else $error("shutdown ignored a wake");
    AST_SDS_DOMAINS: assert property (
        (state == pms_pkg::ST_SDS) |-> !core_pwr_o && io_pwr_o && rtc_en_o && lpo_en_o)
        else $error("shutdown domains wrong");
    AST_HIB_REQ: assert property (
        core_on && !supply_low_i && req_hib_timed_i && !req_hib_ext_i
            |=> (state == pms_pkg::ST_HIB_T))
        else $error("timed hibernate request not taken");
    AST_HIB_E_ONLY_EXT: assert property (
        (state == pms_pkg::ST_HIB_E) && !ext_irq_i && !supply_low_i
            |=> (state == pms_pkg::ST_HIB_E) && !lpo_en_o && !rtc_en_o)
        else $error("interrupt hibernate left without external interrupt");
    AST_BROWNOUT: assert property (
        supply_low_i |=> (state == pms_pkg::ST_OFF) && !core_pwr_o)
        else $error("low supply did not force shutdown");
    AST_LIGHT_WAKE: assert property (
        ((state == pms_pkg::ST_SLEEP) || (state == pms_pkg::ST_IDLE)) && light_wake &&
            !supply_low_i && !req_hib_ext_i && !req_hib_timed_i
            |=> (state == pms_pkg::ST_ACTIVE) && hclk_en_o && !hclk_slow_o)
        else $error("light mode wake did not restore full speed");

    // Domain and wake checks of the deeper states
    AST_SDS_RADIO: assert property (
        (state == pms_pkg::ST_SDS) |-> (radio_task_en_o == $past(radio_task_keep_i)))
        else $error("shutdown radio task does not follow keep request");
    AST_HIB_T_DOMAINS: assert property (
        (state == pms_pkg::ST_HIB_T) |-> !core_pwr_o && io_pwr_o && rtc_en_o && lpo_en_o &&
            !periph_pwr_o)
        else $error("timed hibernate domains wrong");
    AST_HIB_T_HOLD: assert property (
        (state == pms_pkg::ST_HIB_T) && !hib_expire && !supply_low_i
            |=> (state == pms_pkg::ST_HIB_T))
        else $error("timed hibernate left before the timer expired");
    AST_HIB_E_DOMAINS: assert property (
        (state == pms_pkg::ST_HIB_E) |-> io_pwr_o && !rtc_en_o && !lpo_en_o && !core_pwr_o)
        else $error("interrupt hibernate domains wrong");
    AST_AON_DOWN: assert property (
        !core_on |-> !aon_valid_o)
        else $error("always-on memory flagged valid with the core down");
endmodule // pms_sequencer

// ### bench/pms_lpo_model.sv
// Low-power oscillator model that feeds tick pulses to the sequencer
`timescale 1ns/1ps
module pms_lpo_model #(
    parameter int DIV = 3 // System cycles per tick
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic lpo_en_i,
    output logic lpo_tick_o
);
    int cnt; // Divider count
    // Ticks only while powered; a stopped oscillator must not wake anything
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !lpo_en_i) begin
            cnt <= 0;
            lpo_tick_o <= 1'b0;
        end else begin
            cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
            lpo_tick_o <= (cnt == DIV - 1);
        end
    end
endmodule // pms_lpo_model

// ### bench/pms_sequencer_tb.sv
// Self-checking bench of the power mode sequencer
`timescale 1ns/1ps
module pms_sequencer_tb;
    // Request bit positions
    localparam int IDLE = 0, SLEEP = 1, DRS = 2, SHUTDOWN_SLEEP = 3, HT = 4;
    localparam int HE = 5, IRQ = 6, RAD = 7, EXT = 8;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [8:0] req = 9'h000; // Requests and wakes, one bit each
    logic slow = 1'b0; // Supply below threshold
    logic rtk = 1'b0; // Keep radio task
    logic [3:0] allow = 4'h5; // Gate permission per clock
    logic aon_wr = 1'b0;
    logic [3:0] aon_addr = 4'h0;
    logic [7:0] aon_wdata = 8'h00;
    logic tick;
    logic [2:0] state;
    logic run, wt, hen, hslow, ldo, per, core, sram, io, rtc, lpo, rtask, resume, warm, aval;
    logic [3:0] clk_en;
    logic [7:0] aon_rdata;
    logic [10:0] flags; // Packed power and clock flags
    int error_cnt = 0;
    int check_count = 0;
    assign flags = {run, wt, hen, hslow, ldo, per, core, sram, io, rtc, lpo};
    // Half period of 4 ns
    always #4 clk_sys_i = ~clk_sys_i;
    pms_lpo_model #(.DIV(3)) lpo_src (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .lpo_en_i(lpo), .lpo_tick_o(tick));
    // Short hibernate interval keeps the run brief
    pms_sequencer #(.HIB_TICKS(4)) dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .req_idle_i(req[IDLE]), .req_sleep_i(req[SLEEP]), .req_drs_i(req[DRS]),
        .req_sds_i(req[SHUTDOWN_SLEEP]), .req_hib_timed_i(req[HT]), .req_hib_ext_i(req[HE]),
        .irq_i(req[IRQ]), .radio_wake_i(req[RAD]), .ext_irq_i(req[EXT]),
        .supply_low_i(slow), .lpo_tick_i(tick), .radio_task_keep_i(rtk),
        .clk_gate_allow_i(allow), .aon_wr_i(aon_wr), .aon_addr_i(aon_addr),
        .aon_wdata_i(aon_wdata), .state_o(state), .cpu_run_o(run), .cpu_wait_o(wt),
        .hclk_en_o(hen), .hclk_slow_o(hslow), .clk_en_o(clk_en), .ldo_low_o(ldo),
        .periph_pwr_o(per), .core_pwr_o(core), .sram_retain_o(sram), .io_pwr_o(io),
        .rtc_en_o(rtc), .lpo_en_o(lpo), .radio_task_en_o(rtask), .resume_o(resume),
        .warm_boot_o(warm), .aon_valid_o(aval), .aon_rdata_o(aon_rdata));
    // Expected flags per state
    function automatic logic [10:0] exp_flags(input logic [2:0] s);
        case (s)
            3'h0: return 11'h53F;
            3'h1: return 11'h3BF;
            3'h2: return 11'h27F;
            3'h3: return 11'h25F;
            3'h4, 3'h5: return 11'h007;
            3'h6: return 11'h004;
            default: return 11'h000;
        endcase
    endfunction
    // Value compare, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // State code, power flags and clock enables together
    task automatic chk_state(input logic [2:0] s);
        chk(16'(state), 16'(s), "state");
        chk(16'(flags), 16'(exp_flags(s)), "flags");
        chk(16'(clk_en), (s <= 3'h1) ? 16'h000F : (s <= 3'h3) ? {12'h000, ~allow} : 16'h0000,
            "clk_en");
    endtask
    // One-cycle request, sampled at the second edge; settled outputs after
    task automatic pulse(input int b);
        @(posedge clk_sys_i) req[b] <= 1'b1;
        @(posedge clk_sys_i) req[b] <= 1'b0;
        #1;
    endtask
    task automatic t_idle;
        chk_state(3'h0);
        pulse(IDLE);
        chk_state(3'h1);
        pulse(IRQ);
        chk_state(3'h0);
    endtask
    task automatic t_sleep;
        pulse(SLEEP);
        chk_state(3'h2);
        @(posedge clk_sys_i) allow <= 4'h3;
        @(posedge clk_sys_i) #1;
        chk_state(3'h2);
        pulse(IDLE);
        chk_state(3'h2);
        pulse(IRQ);
        chk_state(3'h0);
    endtask
    task automatic t_drs;
        pulse(DRS);
        chk_state(3'h3);
        pulse(RAD);
        chk_state(3'h0);
        chk(16'({resume, warm}), 16'h0002, "resume");
        @(posedge clk_sys_i) #1;
        chk(16'({resume, warm}), 16'h0000, "resume end");
    endtask
    // Store, shut down, wake by radio then by external line, read back
    task automatic t_sds;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_i) aon_wr <= 1'b1;
            aon_addr <= 4'(k + 9);
            aon_wdata <= 8'(8'hA5 + k);
            @(posedge clk_sys_i) aon_wr <= 1'b0;
            rtk <= 1'(k == 0);
            pulse(SHUTDOWN_SLEEP);
            chk_state(3'h4);
            chk(16'({rtask, aval}), (k == 0) ? 16'h0002 : 16'h0000, "radio task");
            pulse(IRQ);
            chk_state(3'h4);
            pulse((k == 0) ? RAD : EXT);
            chk_state(3'h0);
            chk(16'({warm, aval}), 16'h0003, "warm boot");
            @(posedge clk_sys_i) #1;
            chk(16'(warm), 16'h0000, "warm end");
            chk(16'(aon_rdata), 16'(8'hA5 + k), "aon data");
        end
    endtask
    // Timed hibernate entered from sleep, woken by oscillator timer only
    task automatic t_hib_timed;
        int n;
        pulse(SLEEP);
        pulse(HT);
        chk_state(3'h5);
        pulse(EXT);
        chk_state(3'h5);
        n = 0;
        while (state !== 3'h0 && n < 100) begin
            @(posedge clk_sys_i) #1;
            n++;
        end
        chk_state(3'h0);
        chk(16'(warm), 16'h0001, "timer wake");
    endtask
    task automatic t_hib_ext;
        pulse(HE);
        chk_state(3'h6);
        pulse(RAD);
        repeat (40) @(posedge clk_sys_i);
        #1;
        chk_state(3'h6);
        pulse(EXT);
        chk_state(3'h0);
        chk(16'(warm), 16'h0001, "ext wake");
    endtask
    // Low supply from idle forces shutdown until it recovers
    task automatic t_supply;
        pulse(IDLE);
        @(posedge clk_sys_i) slow <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk_state(3'h7);
        @(posedge clk_sys_i) slow <= 1'b0;
        @(posedge clk_sys_i) #1;
        chk_state(3'h0);
        chk(16'(warm), 16'h0001, "supply warm");
    endtask
    // Reset in mid-run from deep retention returns to full-power active
    task automatic t_reset;
        pulse(DRS);
        @(posedge clk_sys_i) srst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i) #1;
        chk_state(3'h0);
        chk(16'({resume, warm, aval}), 16'h0001, "after reset");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i) #1;
        t_idle();
        t_sleep();
        t_drs();
        t_sds();
        t_hib_timed();
        t_hib_ext();
        t_supply();
        t_reset();
        complete_run();
    end
    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // pms_sequencer_tb
